// *** usb_mode_serial_id_regs.sv ***
// USB control, mode configuration and die serial number register bank
module usb_mode_serial_id_regs #(
    // Die serial number; arbitrary value, set per part at integration
    parameter logic [63:0] DIE_SERIAL = 64'h0123_4567_89ab_cdef
) (
    // Clock, power-up reset, clock enable
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    // Wishbone slave
    input wire usb_mode_regs_pkg::wb_req_s wbReq,
    output logic wbAck,
    output logic [31:0] wbDatOut,
    // USB function reset and internal reset
    input wire logic usbFuncReset,
    output logic internalResetN,
    // USB engine controls
    output logic transferDirectionIn,
    output logic setupServiceActive,
    output logic remoteWakeupPulse,
    output logic pullupDrivePin,
    // Serial path select
    output logic infraredPathEnable,
    output logic uartPathEnable,
    // Serial output buffer
    input wire logic uartTxActive,
    output logic serialOutOeN,
    // Clock output
    input wire logic baudOutClock,
    output logic clockOutputPin,
    // EEPROM probe for boot
    output logic eepromProbeReq,
    input wire usb_mode_regs_pkg::eeprom_ans_s eepromAns
);
    import usb_mode_regs_pkg::*;

    // Register state
    logic [7:0] usbControl_r;
    logic [7:0] usbControl_nxt;
    logic [7:0] modeConfiguration_r;
    logic [7:0] modeConfiguration_nxt;
    logic wakeupPulse_r;
    logic wakeupPulse_nxt;

    // Bus slave state
    logic ack_r;
    logic ack_nxt;
    logic [31:0] rdData_r;
    logic [31:0] rdData_nxt;

    // Output state
    logic intRstN_r;
    logic intRstN_nxt;
    logic serialOeN_r;
    logic serialOeN_nxt;

    // Decode helpers
    logic request;
    logic writeStrobe;
    logic [IDX_W-1:0] reqIndex;
    logic [7:0] readByte;

    // Boot result
    logic [63:0] sharedSerial;
    logic bootDone;
    logic eepromUsed;

    // Request decode; the index comes from the shared helper
    assign request = wbReq.cyc && wbReq.stb;
    assign reqIndex = reg_index(wbReq.adr);
    // A write lands on the edge where ack is sampled, as the master expects
    assign writeStrobe = request && wbReq.we && ack_r && wbReq.sel[0];

    // Byte-wide register read view
    always_comb begin
        readByte = 8'h00;
        if (reqIndex >= IDX_SERIAL_BYTE0 && reqIndex <= IDX_SERIAL_BYTE7) begin
            // Byte n sits at base plus n; base has its low three bits clear
            readByte = DIE_SERIAL[{reqIndex[2:0], 3'b000} +: 8];
        end else if (reqIndex == IDX_MODE_CONFIGURATION) begin
            readByte = modeConfiguration_r & MC_STORE_MASK;
        end else if (reqIndex == IDX_USB_CONTROL) begin
            // Wakeup bit is never stored, so it always reads zero
            readByte = usbControl_r & UC_STORE_MASK;
        end
    end

    // Wishbone answer: one wait cycle, ack for one cycle, unmapped reads give zero
    always_comb begin
        ack_nxt = request && !ack_r;
        rdData_nxt = rdData_r;
        if (request && !ack_r) begin
            rdData_nxt = 32'h0000_0000;
            if (reqIndex == IDX_SHARED_SERIAL_LO) begin
                rdData_nxt = sharedSerial[31:0];
            end else if (reqIndex == IDX_SHARED_SERIAL_HI) begin
                rdData_nxt = sharedSerial[63:32];
            end else if (reqIndex == IDX_BOOT_STATUS) begin
                rdData_nxt[BS_DONE] = bootDone;
                rdData_nxt[BS_EEPROM_USED] = eepromUsed;
            end else begin
                rdData_nxt = {24'h00_0000, readByte};
            end
        end
    end

    // Control register writes; only the defined bits are stored
    always_comb begin
        usbControl_nxt = usbControl_r;
        modeConfiguration_nxt = modeConfiguration_r;
        wakeupPulse_nxt = 1'b0;
        if (writeStrobe && reqIndex == IDX_USB_CONTROL) begin
            // Direction, setup flag, reset coupling, infrared and connect bits
            usbControl_nxt = wbReq.dat[7:0] & UC_STORE_MASK;
            wakeupPulse_nxt = wbReq.dat[UC_REMOTE_WAKEUP_REQUEST];
        end
        if (writeStrobe && reqIndex == IDX_MODE_CONFIGURATION) begin
            modeConfiguration_nxt = wbReq.dat[7:0] & MC_STORE_MASK;
        end
    end

    // Power-up reset alone resets these; USB reset never reaches this process
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            usbControl_r <= UC_RESET;
            modeConfiguration_r <= MC_RESET;
            wakeupPulse_r <= 1'b0;
        end else if (ce) begin
            usbControl_r <= usbControl_nxt;
            modeConfiguration_r <= modeConfiguration_nxt;
            wakeupPulse_r <= wakeupPulse_nxt;
        end
    end

    // Bus slave registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ack_r <= 1'b0;
            rdData_r <= 32'h0000_0000;
        end else if (ce) begin
            ack_r <= ack_nxt;
            rdData_r <= rdData_nxt;
        end
    end

    // Internal reset and serial output enable
    always_comb begin
        // Function reset reaches the MCU side only while coupling is on
        intRstN_nxt = !(usbFuncReset && usbControl_r[UC_FUNCTION_RESET_CONNECT]);
        if (modeConfiguration_r[MC_TX_BUFFER_CONTROL_SELECT]) begin
            serialOeN_nxt = modeConfiguration_r[MC_SERIAL_OUTPUT_SOFT_DISABLE];
        end else begin
            // Hardware mode drives the pin only while the UART transmits
            serialOeN_nxt = !uartTxActive;
        end
    end

    // Registered so glitches on the function reset input never reach the MCU
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            intRstN_r <= 1'b0;
            serialOeN_r <= 1'b1;
        end else if (ce) begin
            intRstN_r <= intRstN_nxt;
            serialOeN_r <= serialOeN_nxt;
        end
    end

    // Clock output pin
    clock_output_gen clock_output_pin (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .clockOutputEnable(modeConfiguration_r[MC_CLOCK_OUTPUT_ENABLE]),
        .clockOutputSelect(modeConfiguration_r[MC_CLOCK_OUTPUT_SELECT]),
        .baudOutClock(baudOutClock),
        .clockOutputPin(clockOutputPin)
    );

    // Boot-time shared serial number build
    serial_boot_loader bootLoader (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .dieSerial(DIE_SERIAL),
        .eepromProbeReq(eepromProbeReq),
        .eepromAns(eepromAns),
        .sharedSerial(sharedSerial),
        .bootDone(bootDone),
        .eepromUsed(eepromUsed)
    );

    // Outputs, straight from flip-flops except uartPathEnable, which is inverted
    assign wbAck = ack_r;
    assign wbDatOut = rdData_r;
    assign internalResetN = intRstN_r;
    assign transferDirectionIn = usbControl_r[UC_TRANSFER_DIRECTION];
    assign setupServiceActive = usbControl_r[UC_SETUP_SERVICE_FLAG];
    assign remoteWakeupPulse = wakeupPulse_r;
    assign pullupDrivePin = usbControl_r[UC_UPSTREAM_CONNECT];
    // Exactly one serial path is live at any time
    assign infraredPathEnable = usbControl_r[UC_INFRARED_ENABLE];
    assign uartPathEnable = !usbControl_r[UC_INFRARED_ENABLE];
    assign serialOutOeN = serialOeN_r;

endmodule

// *** usb_mode_regs_pkg.sv ***
// Package: register map, field layout, timing constants and carrier types of the mode register bank
package usb_mode_regs_pkg;

    // Bus geometry: byte address, one register per aligned 32-bit word
    localparam int ADR_W = 18;
    localparam int IDX_W = 16;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_SERIAL_BYTE0 = 16'hffe8;
    localparam logic [IDX_W-1:0] IDX_SERIAL_BYTE4 = 16'hffec;
    localparam logic [IDX_W-1:0] IDX_SERIAL_BYTE5 = 16'hffed;
    localparam logic [IDX_W-1:0] IDX_SERIAL_BYTE6 = 16'hffee;
    localparam logic [IDX_W-1:0] IDX_SERIAL_BYTE7 = 16'hffef;
    localparam logic [IDX_W-1:0] IDX_MODE_CONFIGURATION = 16'hfffb;
    localparam logic [IDX_W-1:0] IDX_USB_CONTROL = 16'hfffc;
    // Boot result registers
    localparam logic [IDX_W-1:0] IDX_SHARED_SERIAL_LO = 16'hff00;
    localparam logic [IDX_W-1:0] IDX_SHARED_SERIAL_HI = 16'hff01;
    localparam logic [IDX_W-1:0] IDX_BOOT_STATUS = 16'hff02;

    // usb_control fields
    localparam int UC_TRANSFER_DIRECTION = 0;
    localparam int UC_SETUP_SERVICE_FLAG = 1;
    localparam int UC_FUNCTION_RESET_CONNECT = 4;
    localparam int UC_REMOTE_WAKEUP_REQUEST = 5;
    localparam int UC_INFRARED_ENABLE = 6;
    localparam int UC_UPSTREAM_CONNECT = 7;
    localparam logic [7:0] UC_RESET = 8'h10;
    localparam logic [7:0] UC_STORE_MASK = 8'hd3;

    // mode_configuration fields
    localparam int MC_TX_BUFFER_CONTROL_SELECT = 0;
    localparam int MC_SERIAL_OUTPUT_SOFT_DISABLE = 1;
    localparam int MC_CLOCK_OUTPUT_ENABLE = 2;
    localparam int MC_CLOCK_OUTPUT_SELECT = 3;
    localparam logic [7:0] MC_RESET = 8'h00;
    localparam logic [7:0] MC_STORE_MASK = 8'h0f;

    // Boot status fields
    localparam int BS_DONE = 0;
    localparam int BS_EEPROM_USED = 1;

    // Default serial number held in the boot descriptors
    localparam logic [63:0] DEFAULT_DESC_SERIAL = 64'h0;

    // Clocking: system clock and the fixed clock output, in kHz
    localparam int SYS_CLK_KHZ = 50000;
    localparam int FIXED_CLK_KHZ = 3556;
    localparam int PHASE_W = 16;
    localparam logic [PHASE_W-1:0] PHASE_INC =
        PHASE_W'((longint'(FIXED_CLK_KHZ) << PHASE_W) / SYS_CLK_KHZ);

    // Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [ADR_W-1:0] adr;
        logic [31:0] dat;
    } wb_req_s;

    // Answer of the I2C EEPROM probe
    typedef struct packed {
        logic done;
        logic present;
        logic valid;
        logic [63:0] serial;
    } eeprom_ans_s;

    // Word index of a byte address
    function automatic logic [IDX_W-1:0] reg_index(input logic [ADR_W-1:0] adr);
        return adr[ADR_W-1:2];
    endfunction

endpackage

// *** clock_output_gen.sv ***
// Clock output pin: fixed-rate clock source, source select and enable gate
module clock_output_gen (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    // Control
    input wire logic clockOutputEnable,
    input wire logic clockOutputSelect,
    input wire logic baudOutClock,
    // Pin
    output logic clockOutputPin
);
    import usb_mode_regs_pkg::*;

    logic [PHASE_W-1:0] phase_r;
    logic [PHASE_W-1:0] phase_nxt;
    logic pin_r;
    logic pin_nxt;

    // Phase accumulator runs free regardless of clockOutputEnable, so the fixed clock is live whenever ce is high
    always_comb begin
        phase_nxt = phase_r + PHASE_INC;
    end

    // Disabled pin is held low; source select picks baud clock or fixed clock
    always_comb begin
        pin_nxt = 1'b0;
        if (clockOutputEnable) begin
            pin_nxt = clockOutputSelect ? phase_r[PHASE_W-1] : baudOutClock;
        end
    end

    // Registered so the pin never glitches on a select change
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phase_r <= '0;
            pin_r <= 1'b0;
        end else if (ce) begin
            phase_r <= phase_nxt;
            pin_r <= pin_nxt;
        end
    end

    assign clockOutputPin = pin_r;

endmodule

// *** serial_boot_loader.sv ***
// Boot sequence that builds the shared serial number from defaults, die id and EEPROM
module serial_boot_loader (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    // Die serial number
    input wire logic [63:0] dieSerial,
    // EEPROM probe
    output logic eepromProbeReq,
    input wire usb_mode_regs_pkg::eeprom_ans_s eepromAns,
    // Result
    output logic [63:0] sharedSerial,
    output logic bootDone,
    output logic eepromUsed
);
    import usb_mode_regs_pkg::*;

    typedef enum logic [4:0] {
        ST_COPY_DEFAULT = 5'b00001,
        ST_READ_DIE = 5'b00010,
        ST_PROBE = 5'b00100,
        ST_WAIT = 5'b01000,
        ST_DONE = 5'b10000
    } boot_state_e;

    boot_state_e state_r;
    boot_state_e state_nxt;
    logic [63:0] serial_r;
    logic [63:0] serial_nxt;
    logic used_r;
    logic used_nxt;

    // Sequence: defaults, then die id, then EEPROM if it holds a valid number
    always_comb begin
        state_nxt = state_r;
        serial_nxt = serial_r;
        used_nxt = used_r;
        case (state_r)
            ST_COPY_DEFAULT: begin
                serial_nxt = DEFAULT_DESC_SERIAL;
                state_nxt = ST_READ_DIE;
            end
            ST_READ_DIE: begin
                serial_nxt = dieSerial;
                state_nxt = ST_PROBE;
            end
            ST_PROBE: begin
                state_nxt = ST_WAIT;
            end
            ST_WAIT: begin
                if (eepromAns.done) begin
                    if (eepromAns.present && eepromAns.valid) begin
                        serial_nxt = eepromAns.serial;
                        used_nxt = 1'b1;
                    end
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                state_nxt = ST_DONE;
            end
            default: begin
                state_nxt = ST_COPY_DEFAULT;
            end
        endcase
    end

    // Runs once per power-up reset only
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_COPY_DEFAULT;
            serial_r <= '0;
            used_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            serial_r <= serial_nxt;
            used_r <= used_nxt;
        end
    end

    assign eepromProbeReq = (state_r == ST_PROBE) || (state_r == ST_WAIT);
    assign sharedSerial = serial_r;
    assign bootDone = (state_r == ST_DONE);
    assign eepromUsed = used_r;

endmodule

// *** usb_mode_serial_id_regs_checker.sv ***
// Checker: bus answer, wakeup pulse, reset coupling and boot probe properties
module usb_mode_serial_id_regs_checker import usb_mode_regs_pkg::*; (
    // Clock and power-up reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Bus
    input wire usb_mode_regs_pkg::wb_req_s wbReq,
    input wire logic wbAck,
    // Controls
    input wire logic usbFuncReset,
    input wire logic internalResetN,
    input wire logic remoteWakeupPulse,
    input wire logic infraredPathEnable,
    input wire logic uartPathEnable,
    // Boot probe
    input wire usb_mode_regs_pkg::eeprom_ans_s eepromAns,
    input wire logic eepromProbeReq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    logic up_r;
    // Set after the first edge out of reset, so $past never looks into reset
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            up_r <= 1'b0;
        end else begin
            up_r <= 1'b1;
        end
    end

    // Bus request taken, and a write of 1 to the wakeup bit being acknowledged
    sequence s_take;
        wbReq.cyc && wbReq.stb && !wbAck;
    endsequence
    sequence s_wakeWrite;
        wbAck && wbReq.we && wbReq.sel[0] && wbReq.dat[5]
            && reg_index(wbReq.adr) == IDX_USB_CONTROL;
    endsequence

    a_ack_follows: assert property (s_take |=> wbAck)
        else $error("ack missing after request");
    a_ack_single: assert property (wbAck |=> !wbAck)
        else $error("ack longer than one cycle");
    a_ack_needs_req: assert property (!(wbReq.cyc && wbReq.stb) |=> !wbAck)
        else $error("ack without request");
    a_wake_pulse: assert property (s_wakeWrite |=> remoteWakeupPulse)
        else $error("wakeup pulse missing");
    a_wake_cause: assert property (remoteWakeupPulse |-> up_r && $past(wbAck && wbReq.we))
        else $error("wakeup pulse without write");
    a_wake_single: assert property (remoteWakeupPulse |=> !remoteWakeupPulse)
        else $error("wakeup pulse too long");
    a_path_excl: assert property (uartPathEnable != infraredPathEnable)
        else $error("serial paths not exclusive");
    a_func_reset: assert property (up_r && !$past(usbFuncReset) |-> internalResetN)
        else $error("internal reset without cause");
    a_probe_ends: assert property (eepromProbeReq && eepromAns.done |=> !eepromProbeReq [*8])
        else $error("probe not ended");
endmodule

bind usb_mode_serial_id_regs usb_mode_serial_id_regs_checker i_chk (.clk_sys, .nrst, .wbReq,
    .wbAck, .usbFuncReset, .internalResetN, .remoteWakeupPulse, .infraredPathEnable,
    .uartPathEnable, .eepromAns, .eepromProbeReq);

// *** usb_mode_serial_id_regs_tb.sv ***
// Testbench: register bank driven over the bus with random and corner stimulus
module usb_mode_serial_id_regs_tb import usb_mode_regs_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [63:0] DIE = 64'h8877_6655_4433_2211;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic usbFuncReset = 1'b0;
    logic uartTxActive = 1'b0;
    logic baudOutClock = 1'b0;
    wb_req_s wbReq = '0;
    eeprom_ans_s eepromAns = '0;
    logic [31:0] wbDatOut;
    logic wbAck, internalResetN, transferDirectionIn, setupServiceActive, remoteWakeupPulse;
    logic pullupDrivePin, infraredPathEnable, uartPathEnable, serialOutOeN, clockOutputPin;
    logic eepromProbeReq;
    logic [15:0] rs = 16'h000c;
    int mismatches = 0;
    int nCompared = 0;

    // 50 MHz system clock
    always #10 clk_sys = ~clk_sys;

    usb_mode_serial_id_regs #(.DIE_SERIAL(DIE)) i_dut (.clk_sys, .nrst, .ce(1'b1), .wbReq,
        .wbAck, .wbDatOut, .usbFuncReset, .internalResetN, .transferDirectionIn,
        .setupServiceActive, .remoteWakeupPulse, .pullupDrivePin, .infraredPathEnable,
        .uartPathEnable, .uartTxActive, .serialOutOeN, .baudOutClock, .clockOutputPin,
        .eepromProbeReq, .eepromAns);

    // Random source; a fixed start keeps runs repeatable
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic print_verdict();
        $display("Compared %0d, mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
        nCompared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_range(input int got, input int lo, input int hi);
        nCompared++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask

    // One classic cycle; held until ack is sampled, then released for a cycle
    task automatic wb_xfer(input logic w, input logic [15:0] idx, input logic [31:0] d,
                           output logic [31:0] q);
        int k;
        @(posedge clk_sys);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: {idx, 2'b00}, dat: d};
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (wbAck !== 1'b1 && k < 20);
        q = wbDatOut;
        wbReq <= '0;
        if (k >= 20) begin
            mismatches++;
            print_verdict();
        end
    endtask

    // Power-up, answer the single EEPROM probe, then read the boot results
    task automatic power_up(input logic present, input logic [63:0] ser);
        logic [31:0] lo, hi, st;
        int k;
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (eepromProbeReq !== 1'b1 && k < 50);
        if (k >= 50) begin
            mismatches++;
            print_verdict();
        end
        eepromAns <= '{done: 1'b1, present: present, valid: 1'b1, serial: ser};
        @(posedge clk_sys);
        eepromAns <= '0;
        wb_xfer(1'b0, IDX_SHARED_SERIAL_LO, 32'h0, lo);
        wb_xfer(1'b0, IDX_SHARED_SERIAL_HI, 32'h0, hi);
        wb_xfer(1'b0, IDX_BOOT_STATUS, 32'h0, st);
        check_val({hi, lo}, present ? ser : DIE);
        check_val(st[1:0], {present, 1'b1});
    endtask

    // Counts rising edges on the clock pin, optionally toggling the baud clock
    task automatic count_rises(input int cyc, input bit tog, output int c);
        logic prev;
        prev = clockOutputPin;
        c = 0;
        for (int i = 0; i < cyc; i++) begin
            @(posedge clk_sys);
            if (tog && i % 4 == 0) begin
                baudOutClock <= ~baudOutClock;
            end
            c += (clockOutputPin && !prev) ? 1 : 0;
            prev = clockOutputPin;
        end
    endtask

    // Main sequence
    initial begin
        logic [31:0] q;
        logic [7:0] v;
        int c;
        power_up(1'b0, 64'h0);
        wb_xfer(1'b0, IDX_USB_CONTROL, 32'h0, q);
        check_val(q, 32'h10);
        wb_xfer(1'b0, IDX_MODE_CONFIGURATION, 32'h0, q);
        check_val(q, 32'h0);
        check_val({pullupDrivePin, clockOutputPin}, 2'b00);
        for (int n = 0; n < 8; n++) begin
            rs = lfsr(rs);
            wb_xfer(1'b1, IDX_SERIAL_BYTE0 + 16'(n), {16'h0, rs}, q);
            wb_xfer(1'b0, IDX_SERIAL_BYTE0 + 16'(n), 32'h0, q);
            check_val(q, DIE[8*n+:8]);
        end
        wb_xfer(1'b1, 16'h1234, 32'hff, q);
        wb_xfer(1'b0, 16'h1234, 32'h0, q);
        check_val(q, 32'h0);
        for (int n = 0; n < 12; n++) begin
            rs = lfsr(rs);
            v = (n == 0) ? 8'hff : (n == 1) ? 8'h00 : rs[7:0];
            wb_xfer(1'b1, IDX_USB_CONTROL, {24'h0, v}, q);
            settle(1);
            check_val({pullupDrivePin, infraredPathEnable, setupServiceActive,
                       transferDirectionIn}, {v[7], v[6], v[1], v[0]});
            wb_xfer(1'b0, IDX_USB_CONTROL, 32'h0, q);
            check_val(q, v & 8'hd3);
        end
        wb_xfer(1'b1, IDX_USB_CONTROL, 32'h90, q);
        wb_xfer(1'b1, IDX_MODE_CONFIGURATION, 32'h03, q);
        usbFuncReset <= 1'b1;
        settle(2);
        check_val(internalResetN, 1'b0);
        wb_xfer(1'b0, IDX_USB_CONTROL, 32'h0, q);
        check_val(q, 32'h90);
        wb_xfer(1'b0, IDX_MODE_CONFIGURATION, 32'h0, q);
        check_val(q, 32'h03);
        wb_xfer(1'b1, IDX_USB_CONTROL, 32'h80, q);
        settle(2);
        check_val(internalResetN, 1'b1);
        usbFuncReset <= 1'b0;
        for (int n = 0; n < 4; n++) begin
            rs = lfsr(rs);
            uartTxActive <= rs[0];
            wb_xfer(1'b1, IDX_MODE_CONFIGURATION, {24'h0, rs[7:2], n[1:0]}, q);
            settle(2);
            check_val(serialOutOeN, n[0] ? n[1] : !rs[0]);
            wb_xfer(1'b0, IDX_MODE_CONFIGURATION, 32'h0, q);
            check_val(q, {rs[7:2], n[1:0]} & 8'h0f);
        end
        wb_xfer(1'b1, IDX_MODE_CONFIGURATION, 32'h00, q);
        count_rises(40, 1'b1, c);
        check_range(c, 0, 0);
        wb_xfer(1'b1, IDX_MODE_CONFIGURATION, 32'h0c, q);
        count_rises(140, 1'b0, c);
        check_range(c, 9, 11);
        wb_xfer(1'b1, IDX_MODE_CONFIGURATION, 32'h04, q);
        count_rises(80, 1'b1, c);
        check_range(c, 9, 11);
        rs = lfsr(rs);
        power_up(1'b1, {rs, ~rs, rs ^ 16'h5a5a, 16'h0f0f});
        wb_xfer(1'b0, IDX_USB_CONTROL, 32'h0, q);
        check_val(q, 32'h10);
        print_verdict();
    end
endmodule
